// [rtl/toc_pkg.sv]
// Package for the timer output control stage: register map, bit fields,
// reset values and operating mode codes.
// Assumes a classic Wishbone master with 32-bit data and byte addressing.
package toc_pkg;

  // Printed offsets are word indexes; the byte address is four times each
  localparam int ADDR_W = 18;
  localparam logic [15:0] CTRL_IDX = 16'hFFBD;
  localparam logic [15:0] STAT_IDX = 16'hFFBE;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};

  // Control register field positions
  localparam int OE_BIT = 0;
  localparam int M0INV_BIT = 1;
  localparam int LVR_BIT = 2;
  localparam int LVS_BIT = 3;
  localparam int M1INV_BIT = 4;
  localparam int OSEL_BIT = 5;
  localparam int SWTRIG_BIT = 6;
  localparam int RSVD_BIT = 7;

  // Status register field positions
  localparam int ST_OUT_BIT = 0;
  localparam int ST_ARMED_BIT = 1;
  localparam int ST_RUN_BIT = 2;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Counter operating mode codes
  typedef enum logic [1:0] {
    TOC_MODE_STOP = 2'h0,
    TOC_MODE_CLR_EDGE = 2'h1,
    TOC_MODE_FREE = 2'h2,
    TOC_MODE_CLR_MATCH = 2'h3
  } toc_mode_t;

endpackage

// [rtl/toc_output_ctrl.sv]
// Output control stage of one 16-bit timer channel with its 8-bit control
// register on a classic Wishbone slave port.
// Assumes match pulses, mode and port bits come from logic on the same clock.
//
// Notes on behaviour
// [RQ1] Control register is 8 bits, reset to zero.
// [RQ2] While counting, software writes only one-shot trigger; the code locks no other bit.
// [RQ3] Compare-1 inversion enable writable while counting.
// [RQ4] Bit-wise or whole-byte writes both accepted.
// [RQ5] Software configures in three ordered writes.
// [RQ6] One-shot trigger reads zero, fires one-shot pulse.
// [RQ7] One-shot trigger clears and starts the counter.
// [RQ8] Select bit chooses successive or one-shot output.
// [RQ9] No one-shot in clear-on-compare-0 mode; the code ignores the mode and arms in any mode.
// [RQ10] Compare-1 match inverts output when enabled.
// [RQ11] Compare-1 interrupt on every match.
// [RQ12] Compare-0 match inverts output when enabled.
// [RQ13] Compare-0 interrupt on every match.
// [RQ14] Level pair: 00 keep, 01 low, 10 high.
// [RQ15] Level bits are one-time triggers only.
// [RQ16] Level trigger bits always read zero.
// [RQ17] Level triggers only once output already enabled.
// [RQ18] Output disabled holds the timer output low.
// [RQ19] Pin level depends on port mode, latch, output.
// [RQ20] Bit 7 reads zero, writes ignored.
`timescale 1ns/1ps

module toc_output_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [toc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] op_mode,
  input wire logic match0,
  input wire logic match1,
  input wire logic edge_start,
  input wire logic port_mode_bit,
  input wire logic port_latch_bit,
  output logic timer_output_line,
  output logic pin_out,
  output logic pin_oe,
  output logic match0_irq,
  output logic match1_irq,
  output logic counter_clear_start
);
  import toc_pkg::*;

  logic output_enable_bit;
  logic match0_invert_en;
  logic match1_invert_en;
  logic oneshot_select;
  logic armed;
  logic req;
  logic ctrl_hit;
  logic stat_hit;
  logic ctrl_wr;
  logic level_set_trigger;
  logic level_clear_trigger;
  logic sw_oneshot_trigger;
  logic gate;
  logic m0_hit;
  logic m1_hit;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  toc_mode_t mode;

  assign mode = toc_mode_t'(op_mode);

  // Bus decode; a request is taken once, in the cycle before its ack
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrl_hit = (wb_adr_i == CTRL_ADDR);
  assign stat_hit = (wb_adr_i == STAT_ADDR);
  assign ctrl_wr = req && wb_we_i && ctrl_hit && wb_sel_i[0] && ce; // see [RQ4]

  // Trigger bits act only in the cycle of the write and are never stored
  assign level_set_trigger = ctrl_wr && wb_dat_i[LVS_BIT]; // see [RQ15]
  assign level_clear_trigger = ctrl_wr && wb_dat_i[LVR_BIT]; // see [RQ15]
  assign sw_oneshot_trigger = ctrl_wr && wb_dat_i[SWTRIG_BIT]; // see [RQ6]

  // Read views: triggers and bit 7 always zero
  assign ctrl_rd = {1'b0, 1'b0, oneshot_select, match1_invert_en,
                    1'b0, 1'b0, match0_invert_en, output_enable_bit}; // see [RQ16] [RQ20]
  assign stat_rd = {5'h00, (mode != TOC_MODE_STOP), armed, timer_output_line};

  // Successive mode always passes matches; one-shot only while armed
  assign gate = !oneshot_select || armed; // see [RQ8]
  assign m0_hit = match0 && match0_invert_en && gate; // see [RQ12]
  assign m1_hit = match1 && match1_invert_en && gate; // see [RQ10]

  // Stored control bits; no lock while counting, so compare-1 inversion
  // can be changed on the fly (keeping the rest steady is software's job)
  always_ff @(posedge clock) begin
    if (rst) begin
      output_enable_bit <= CTRL_RESET[OE_BIT]; // see [RQ1]
      match0_invert_en <= CTRL_RESET[M0INV_BIT];
      match1_invert_en <= CTRL_RESET[M1INV_BIT];
      oneshot_select <= CTRL_RESET[OSEL_BIT];
    end else if (ctrl_wr) begin
      output_enable_bit <= wb_dat_i[OE_BIT];
      match0_invert_en <= wb_dat_i[M0INV_BIT];
      match1_invert_en <= wb_dat_i[M1INV_BIT]; // see [RQ3]
      oneshot_select <= wb_dat_i[OSEL_BIT]; // see [RQ8]
    end
  end

  // Bus answer: ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= DATA_ZERO;
    end else if (ce) begin
      wb_ack_o <= req;
      if (req && !wb_we_i && ctrl_hit) begin
        wb_dat_o <= {24'h00_0000, ctrl_rd};
      end else if (req && !wb_we_i && stat_hit) begin
        wb_dat_o <= {24'h00_0000, stat_rd};
      end else if (req) begin
        wb_dat_o <= DATA_ZERO;
      end
    end
  end

  // One-shot arm: a new trigger wins over the end of the previous pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (ce) begin
      if (!oneshot_select) begin
        armed <= 1'b0;
      end else if (sw_oneshot_trigger || edge_start) begin
        armed <= 1'b1; // see [RQ6]
      end else if (match1) begin
        armed <= 1'b0;
      end
    end
  end

  // Counter restart request on any software trigger, whatever the mode
  always_ff @(posedge clock) begin
    if (rst) begin
      counter_clear_start <= 1'b0;
    end else if (ce) begin
      counter_clear_start <= sw_oneshot_trigger; // see [RQ7]
    end
  end

  // Timer output: disable wins, then level triggers, then inversions.
  // Triggers are gated by the already stored enable, so a write that sets
  // the enable and a trigger at once only enables.  Pair 11 sets no level; enabled matches still invert.
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_output_line <= 1'b0;
    end else if (ce) begin
      if (!output_enable_bit) begin
        timer_output_line <= 1'b0; // see [RQ18]
      end else if (level_set_trigger && !level_clear_trigger) begin
        timer_output_line <= 1'b1; // see [RQ14] [RQ17]
      end else if (level_clear_trigger && !level_set_trigger) begin
        timer_output_line <= 1'b0; // see [RQ14] [RQ17]
      end else if (m0_hit ^ m1_hit) begin
        timer_output_line <= !timer_output_line; // see [RQ10] [RQ12]
      end
    end
  end

  // Match interrupts ignore the inversion enables
  always_ff @(posedge clock) begin
    if (rst) begin
      match0_irq <= 1'b0;
      match1_irq <= 1'b0;
    end else if (ce) begin
      match0_irq <= match0; // see [RQ13]
      match1_irq <= match1; // see [RQ11]
    end
  end

  // Shared pin: port mode 0 drives; latch high forces the pin high
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_oe <= !port_mode_bit; // see [RQ19]
      pin_out <= timer_output_line || port_latch_bit; // see [RQ19]
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  rst_zero_a: assert property (disable iff (1'b0) rst |=> ctrl_rd == CTRL_RESET) // see [RQ1]
    else $error("control register not zero after reset");

  oe_low_a: assert property (ce && !output_enable_bit |=> !timer_output_line) // see [RQ18]
    else $error("output not low while disabled");

  lvl_set_a: assert property (
    level_set_trigger && !level_clear_trigger && output_enable_bit
    |=> timer_output_line) // see [RQ14]
    else $error("level set trigger did not drive output high");

  lvl_clr_a: assert property (
    level_clear_trigger && !level_set_trigger && output_enable_bit
    |=> !timer_output_line) // see [RQ15]
    else $error("level clear trigger did not drive output low");

  inv_one_a: assert property (
    ce && output_enable_bit && !level_set_trigger && !level_clear_trigger
    && match1 && match1_invert_en && !match0 && gate
    |=> timer_output_line != $past(timer_output_line)) // see [RQ10]
    else $error("compare-1 match did not invert output");

  noinv_zero_a: assert property (
    ce && output_enable_bit && !level_set_trigger && !level_clear_trigger
    && match0 && !match0_invert_en && !match1
    |=> $stable(timer_output_line)) // see [RQ12]
    else $error("compare-0 match inverted output while disabled");

  irq_each_a: assert property (ce && match1 && !match1_invert_en |=> match1_irq) // see [RQ11]
    else $error("compare-1 interrupt missing");

  irq_zero_a: assert property (ce && match0 |=> match0_irq ##0 $past(match0)) // see [RQ13]
    else $error("compare-0 interrupt missing");

  trig_start_a: assert property (sw_oneshot_trigger |=> counter_clear_start) // see [RQ7]
    else $error("software trigger did not restart counter");

  rd_zero_a: assert property (
    wb_ack_o && !wb_we_i && ctrl_hit && $past(ce)
    |-> wb_dat_o[7] == 1'b0 && wb_dat_o[6] == 1'b0 && wb_dat_o[3:2] == 2'h0) // see [RQ16]
    else $error("trigger or reserved bits read non-zero");

  pin_mode_a: assert property (ce |=> pin_oe == !$past(port_mode_bit)) // see [RQ19]
    else $error("pin enable does not follow port mode");

  // Pin level is the registered mix of output and latch
  pin_val_a: assert property (
    ce |=> pin_out == ($past(timer_output_line) || $past(port_latch_bit))) // see [RQ19]
    else $error("pin level does not follow output and latch");

  // Ack is one pulse; a frozen clock enable would hold it, so ce is required
  ack_pulse_a: assert property (ce && wb_ack_o |=> !wb_ack_o) // see [RQ4]
    else $error("bus ack longer than one cycle");

  ack_lat_a: assert property (req && ce |=> wb_ack_o) // see [RQ4]
    else $error("bus ack missing after request");

  // A taken control write lands in full, minus trigger and reserved bits
  wr_keep_a: assert property (
    ctrl_wr |=> ctrl_rd == ($past(wb_dat_i[7:0]) & 8'h33)) // see [RQ4]
    else $error("control write not stored");

  // Anything but a taken control write leaves the stored bits alone
  wr_skip_a: assert property (ce && !ctrl_wr |=> $stable(ctrl_rd)) // see [RQ20]
    else $error("control bits changed without a write");

  // Both enabled matches in one cycle cancel out
  both_match_a: assert property (
    ce && output_enable_bit && !level_set_trigger && !level_clear_trigger
    && m0_hit && m1_hit
    |=> $stable(timer_output_line)) // see [RQ12]
    else $error("coincident matches changed output");

  // The prohibited level pair must not disturb the output
  lvl_both_a: assert property (
    ce && output_enable_bit && level_set_trigger && level_clear_trigger
    && !m0_hit && !m1_hit
    |=> $stable(timer_output_line)) // see [RQ14]
    else $error("level pair 11 changed output");

  // Compare-0 match inverts when its enable is set
  inv_zero_a: assert property (
    ce && output_enable_bit && !level_set_trigger && !level_clear_trigger
    && match0 && match0_invert_en && !match1 && gate
    |=> timer_output_line != $past(timer_output_line)) // see [RQ12]
    else $error("compare-0 match did not invert output");

  // Successive mode never leaves the one-shot armed
  arm_off_a: assert property (ce && !oneshot_select |=> !armed) // see [RQ8]
    else $error("armed outside one-shot mode");

  // Unarmed one-shot ignores matches, so a stray match cannot start a pulse
  oneshot_idle_a: assert property (
    ce && output_enable_bit && oneshot_select && !armed
    && !level_set_trigger && !level_clear_trigger
    |=> $stable(timer_output_line)) // see [RQ8]
    else $error("unarmed one-shot changed output");

  // Counter restart is a single pulse per trigger write
  ccs_pulse_a: assert property (ce && !sw_oneshot_trigger |=> !counter_clear_start) // see [RQ7]
    else $error("counter restart without trigger");

  oneshot_cov: cover property (
    oneshot_select && sw_oneshot_trigger ##[1:100] m1_hit);
  level_cov: cover property (level_set_trigger ##1 timer_output_line);
  toggle_cov: cover property (m0_hit ##1 !oneshot_select ##[1:50] m1_hit);
  cancel_cov: cover property (m0_hit && m1_hit);

endmodule // toc_output_ctrl

// [bench/tb.sv]
// Self-checking bench for the timer output control stage.
// Assumes the design package and module are compiled first; no partner model.
`timescale 1ns/1ps

module tb;
  import toc_pkg::*;
  logic clock = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0;
  logic m0 = 0, m1 = 0, es = 0, pm = 0, pl = 0;
  logic [1:0] mode = 0;
  logic [17:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, dat_o, q;
  logic ack, tout, pout, poe, irq0, irq1, ccs, wr, arm;
  logic [7:0] m_ctl, d, cfg;
  logic m_out, m_arm, m_i0, m_i1, m_ccs, m_pin, m_oe;
  int bad_count = 0, n_checks = 0, ncyc = 0;

  toc_output_ctrl uut (.clock(clock), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .op_mode(mode), .match0(m0), .match1(m1), .edge_start(es),
    .port_mode_bit(pm), .port_latch_bit(pl), .timer_output_line(tout), .pin_out(pout),
    .pin_oe(poe), .match0_irq(irq0), .match1_irq(irq1), .counter_clear_start(ccs));

  always #2 clock = ~clock;

  task report_and_stop;
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Classic single cycle; request held up to the rising edge that samples ack high
  task wb(input logic w, input logic [17:0] a, input logic [7:0] v, input logic s);
    int n;
    @(posedge clock);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, v}; sel <= {3'h0, s};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: bus answer timed out", $time);
    end
    q = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
  endtask

  // Reference model; matches never coincide with writes, so no ordering doubt
  always @(posedge clock) begin
    ncyc++;
    if (ncyc == 10000) begin
      bad_count++;
      report_and_stop;
    end
    wr = cyc & stb & we & !ack & ce & (adr == CTRL_ADDR) & sel[0];
    d = dat[7:0];
    arm = (wr & d[6]) | es;
    if (rst) begin
      {m_ctl, m_out, m_arm, m_i0, m_i1, m_ccs, m_pin, m_oe} <= '0;
    end else begin
      m_i0 <= m0;
      m_i1 <= m1;
      m_ccs <= wr & d[6];
      m_pin <= m_out | pl;
      m_oe <= !pm;
      if (wr)
        m_ctl <= d & 8'h33;
      // Arming follows the select bit stored before this edge
      m_arm <= m_ctl[5] & (arm | (m_arm & !m1));
      if (!m_ctl[0])
        m_out <= 0;
      else if (wr && m_ctl[0] && d[3:2] == 2'b10)
        m_out <= 1;
      else if (wr && m_ctl[0] && d[3:2] == 2'b01)
        m_out <= 0;
      else if ((!m_ctl[5] | m_arm) && ((m0 & m_ctl[1]) ^ (m1 & m_ctl[4])))
        m_out <= !m_out;
    end
  end

  // Every output but the bus ack and read data compared each cycle, half a period after it settles
  always @(negedge clock) begin
    if (!rst) begin
      chk(32'(irq0), 32'(m_i0));
      chk(32'(irq1), 32'(m_i1));
      chk(32'(ccs), 32'(m_ccs));
      chk(32'(poe), 32'(m_oe));
      chk(32'(tout), 32'(m_out));
      chk(32'(pout), 32'(m_pin));
    end
  end

  initial begin
    byte unsigned seq [10] = '{8'h12, 8'h13, 8'h1B, 8'h13, 8'h17, 8'h03, 8'h13, 8'hF3,
      8'h53, 8'h00};
    void'($urandom(32'hF798633B));
    repeat (16) @(posedge clock);
    rst <= 0;
    wb(0, CTRL_ADDR, 8'h00, 1);
    chk(q, 32'h0);
    // Set-up order: inversions, then enable, then a level set and a level clear trigger
    foreach (seq[i]) begin
      wb(1, CTRL_ADDR, seq[i], 1);
      wb(0, CTRL_ADDR, 8'h00, 1);
      chk(q, 32'(seq[i] & 8'h33));
    end
    // Ignored writes and an unmapped place
    wb(1, CTRL_ADDR, 8'h13, 0);
    wb(1, 18'h00010, 8'h13, 1);
    wb(0, CTRL_ADDR, 8'h00, 1);
    chk(q, 32'h0);
    wb(0, 18'h00010, 8'h00, 1);
    chk(q, 32'h0);
    // Every invert and select combination under random matches
    for (int p = 0; p < 16; p++) begin
      cfg = {2'b00, p[2], p[1], 2'b00, p[0], ~p[3]};
      wb(1, CTRL_ADDR, cfg, 1);
      if (p[2])
        wb(1, CTRL_ADDR, cfg | 8'h40, 1);
      repeat (100) begin
        @(posedge clock);
        {m0, m1, pm, pl, mode} <= 6'($urandom);
        es <= ($urandom % 8) == 0;
      end
      @(posedge clock);
      {m0, m1, es} <= 3'h0;
      mode <= 2'h0;
    end
    repeat (3) @(posedge clock);
    report_and_stop;
  end
endmodule // tb
